// *** verilog/sysbus_pkg.sv ***
package sysbus_pkg;
    // bus geometry
    localparam int ADW      = 32;           // address/data width
    localparam int CHKW     = 4;            // check bits, one per byte
    localparam int CMDW     = 9;            // command width
    localparam int BLK_WORDS = 8;           // block transfer length
    localparam int MODE_BITS = 256;         // boot mode stream length
    localparam int SER_DIV   = 256;         // serial clock divider
    localparam int SER_HALF  = SER_DIV / 2;
    localparam int MULT_MIN  = 2;
    localparam int MULT_MAX  = 8;

    // command encoding: bit 8 = 1 data cycle, 0 address cycle
    localparam int CMD_DATA_BIT = 8;
    localparam int CMD_LAST_BIT = 5;        // data: last word marker
    localparam int CMD_CST_LSB  = 3;        // data: 2-bit cache state
    localparam int CMD_TYPE_LSB = 5;        // address: 3-bit type
    localparam int CMD_BLK_BIT  = 3;        // address: block request
    localparam int CMD_SIZE_LSB = 0;        // address: 3-bit size-1

    localparam logic [2:0] TYPE_READ  = 3'h0;
    localparam logic [2:0] TYPE_WRITE = 3'h2;
    localparam logic [2:0] TYPE_NULL  = 3'h3;

    // mode stream field positions
    localparam int MODE_RATE_LSB = 1;       // writeback pattern, 4 bits
    localparam int MODE_MULT_LSB = 5;       // multiplier code, 3 bits
    localparam logic [2:0] MULT_RESERVED = 3'h7;

    // even parity across a byte lane
    function automatic logic [CHKW-1:0] lane_par(input logic [ADW-1:0] d);
        logic [CHKW-1:0] p;
        p = '0;
        for (int i = 0; i < CHKW; i++) begin
            p[i] = ^d[i*8 +: 8];
        end
        return p;
    endfunction : lane_par

    // writeback pattern: gap cycles after each word, by rate code
    function automatic logic [2:0] rate_gap(input logic [3:0] code);
        logic [2:0] g;
        g = 3'h0;
        case (code)
            4'h0: g = 3'h0;
            4'h1, 4'h3: g = 3'h1;
            4'h2, 4'h6: g = 3'h2;
            4'h4, 4'h8: g = 3'h3;
            4'h5: g = 3'h4;
            4'h7: g = 3'h6;
            default: g = 3'h0;
        endcase
        return g;
    endfunction : rate_gap
endpackage : sysbus_pkg

// *** verilog/sysbus_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface sysbus_if;
    logic [31:0] ad_cpu_out;       // cpu address/data drive
    logic        ad_cpu_oe_n;      // low while cpu drives
    logic [31:0] ad_agt_out;
    logic        ad_agt_oe_n;
    logic [3:0]  chk_cpu_out;
    logic [3:0]  chk_agt_out;
    logic [8:0]  cmd_cpu_out;
    logic [8:0]  cmd_agt_out;
    logic [31:0] sys_addr_data_bus;     // resolved level
    logic [3:0]  addr_data_check_bits;
    logic [8:0]  sys_command_bus;
    logic        cmd_par_cpu;           // command parity, cpu drive
    logic        cmd_par_agt;
    logic        cmd_par;
    logic        read_accept_n;
    logic        write_accept_n;
    logic        bus_takeover_req_n;
    logic        release_n;
    logic        cpu_drive_valid_n;
    logic        agent_drive_valid_n;
    logic        power_good;
    logic        mode_clk;
    logic        mode_din;

    // wire resolution; the agent drives while cpu is off
    assign sys_addr_data_bus    = !ad_cpu_oe_n ? ad_cpu_out : ad_agt_out;
    assign addr_data_check_bits = !ad_cpu_oe_n ? chk_cpu_out : chk_agt_out;
    assign sys_command_bus      = !ad_cpu_oe_n ? cmd_cpu_out : cmd_agt_out;
    assign cmd_par              = !ad_cpu_oe_n ? cmd_par_cpu : cmd_par_agt;

    modport cpu (
        output ad_cpu_out, ad_cpu_oe_n, chk_cpu_out, cmd_cpu_out,
        output cmd_par_cpu, release_n, cpu_drive_valid_n, mode_clk,
        input  sys_addr_data_bus, addr_data_check_bits, sys_command_bus,
        input  cmd_par, read_accept_n, write_accept_n,
        input  bus_takeover_req_n, agent_drive_valid_n, power_good,
        input  mode_din
    );
    modport agent (
        output ad_agt_out, ad_agt_oe_n, chk_agt_out, cmd_agt_out,
        output cmd_par_agt, read_accept_n, write_accept_n,
        output bus_takeover_req_n, agent_drive_valid_n, mode_din,
        input  sys_addr_data_bus, addr_data_check_bits, sys_command_bus,
        input  cmd_par, release_n, cpu_drive_valid_n, mode_clk,
        input  ad_cpu_oe_n, power_good
    );
endinterface : sysbus_if
`default_nettype wire

// *** verilog/sysbus_cpu_end.sv ***
// What this block does
// - 32-bit multiplexed address/data with 4 check bits
// - 9-bit command bus carries parity
// - command tells address cycle from data
// - address: type; data: last marker, cache state
// - command bus driven by whichever party owns it
// - single 1-8 byte and 8-word block transfers
// - low 3 address bits byte address, command size
// - sample accept lines before dropping the address
// - takeover request answered by release, slave state
// - output valid only with valid cpu drive
// - agent marks its valid words with input valid
// - one processor request outstanding at a time
// - agent issues only read response or null
// - read: valid, address, read command together
// - read accepted: tristate, release, agent returns data
// - write pace from mode stream, read pace agent's
// - pipeline multiplier 2..8 chosen at reset
// - mode serial clock is ref clock over 256
// - read 256 mode bits after power good
// - mode bit 0 first, ascending to 255
`timescale 1ns/10ps
`default_nettype none
module sysbus_cpu_end (
    input  wire logic        ref_clk,     // bus reference clock
    input  wire logic        resetn,      // synchronous reset
    sysbus_if.cpu            bus,         // system interface
    input  wire logic        req_valid,   // start a request
    input  wire logic        req_write,   // 1 write, 0 read
    input  wire logic        req_block,   // 8-word block
    input  wire logic [31:0] req_addr,    // byte address
    input  wire logic [2:0]  req_size,    // bytes minus one
    input  wire logic [31:0] req_wdata,   // write word
    output logic             req_ready,   // idle, request taken
    output logic             wdata_take,  // next write word wanted
    output logic             rdata_valid, // read word strobe
    output logic [31:0]      rdata,       // read word
    output logic             rdata_last,  // last read word
    output logic             rdata_perr,  // check bit or command parity mismatch
    output logic             mode_done,   // mode stream loaded
    output logic [255:0]     mode_word,   // captured mode bits
    output logic [3:0]       pll_mult     // pipeline multiplier
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_WDATA = 3'b010,
        ST_WGAP  = 3'b011,
        ST_RWAIT = 3'b100,
        ST_SLAVE = 3'b101
    } state_e;

    typedef struct packed {
        state_e       st;
        logic         wr;
        logic         blk;
        logic [3:0]   wcnt;
        logic [2:0]   gap;
        logic [31:0]  ad;
        logic [8:0]   cmd;
        logic         oe_n;
        logic         vld_n;
        logic         rel_n;
        logic         rdy;
        logic         take;
        logic         rv;
        logic [31:0]  rd;
        logic         rl;
        logic         rp;
        logic [7:0]   div;
        logic         sclk;
        logic [8:0]   bits;
        logic         pg_seen;
        logic         done;
        logic [255:0] mode;
        logic [3:0]   mult;
    } st_s;

    st_s s_r;
    st_s s_nxt;
    logic cmd_is_data;
    logic rate_cmd_last;

    assign cmd_is_data   = bus.sys_command_bus[sysbus_pkg::CMD_DATA_BIT];
    assign rate_cmd_last = (s_r.wcnt == 4'(sysbus_pkg::BLK_WORDS - 1))
                           || !s_r.blk;

    // one next-state process for the whole end
    always_comb begin
        s_nxt      = s_r;
        s_nxt.take = 1'b0;
        s_nxt.rv   = 1'b0;
        // serial mode clock, ref over 256, runs forever
        if (s_r.div == 8'(sysbus_pkg::SER_HALF - 1)) begin
            s_nxt.div  = 8'h00;
            s_nxt.sclk = !s_r.sclk;
        end else begin
            s_nxt.div = s_r.div + 8'h01;
        end
        if (bus.power_good) begin
            s_nxt.pg_seen = 1'b1;
        end
        // sample at the rising serial edge: bit 0 present at power good
        if (s_r.pg_seen && !s_r.done && !s_r.sclk
            && s_r.div == 8'(sysbus_pkg::SER_HALF - 1)) begin
            s_nxt.mode[s_r.bits[7:0]] = bus.mode_din;
            s_nxt.bits = s_r.bits + 9'h001;
            if (s_r.bits == 9'(sysbus_pkg::MODE_BITS - 1)) begin
                s_nxt.done = 1'b1;
                // reserved code falls back to the lowest factor
                if (s_r.mode[sysbus_pkg::MODE_MULT_LSB +: 3]
                    == sysbus_pkg::MULT_RESERVED) begin
                    s_nxt.mult = 4'(sysbus_pkg::MULT_MIN);
                end else begin
                    s_nxt.mult = 4'(sysbus_pkg::MULT_MIN)
                        + {1'b0, s_r.mode[sysbus_pkg::MODE_MULT_LSB +: 3]};
                end
            end
        end
        case (s_r.st)
            ST_IDLE: begin
                s_nxt.rdy = s_r.done && bus.bus_takeover_req_n;
                if (!bus.bus_takeover_req_n) begin
                    s_nxt.st    = ST_SLAVE;
                    s_nxt.rel_n = 1'b0;
                    s_nxt.oe_n  = 1'b1;
                    s_nxt.rdy   = 1'b0;
                end else if (req_valid && s_r.rdy) begin
                    s_nxt.rdy   = 1'b0;
                    s_nxt.st    = ST_ADDR;
                    s_nxt.wr    = req_write;
                    s_nxt.blk   = req_block;
                    s_nxt.wcnt  = 4'h0;
                    s_nxt.ad    = req_addr;
                    s_nxt.cmd   = '0;
                    s_nxt.cmd[sysbus_pkg::CMD_TYPE_LSB +: 3] =
                        req_write ? sysbus_pkg::TYPE_WRITE
                                  : sysbus_pkg::TYPE_READ;
                    s_nxt.cmd[sysbus_pkg::CMD_BLK_BIT] = req_block;
                    s_nxt.cmd[sysbus_pkg::CMD_SIZE_LSB +: 3] =
                        req_block ? 3'h7 : req_size;
                    s_nxt.oe_n  = 1'b0;
                    s_nxt.vld_n = 1'b0;
                end
            end
            ST_ADDR: begin
                // address holds until the matching accept line is seen
                if (s_r.wr && !bus.write_accept_n) begin
                    s_nxt.st    = ST_WDATA;
                    s_nxt.ad    = req_wdata;
                    s_nxt.take  = 1'b1;
                    s_nxt.cmd   = '0;
                    s_nxt.cmd[sysbus_pkg::CMD_DATA_BIT] = 1'b1;
                    s_nxt.cmd[sysbus_pkg::CMD_LAST_BIT] = !s_r.blk;
                end else if (!s_r.wr && !bus.read_accept_n) begin
                    s_nxt.st    = ST_RWAIT;
                    s_nxt.oe_n  = 1'b1;
                    s_nxt.vld_n = 1'b1;
                    s_nxt.rel_n = 1'b0;
                end
            end
            ST_WDATA: begin
                // one write word driven; pattern from the mode stream
                s_nxt.gap = sysbus_pkg::rate_gap(
                    s_r.mode[sysbus_pkg::MODE_RATE_LSB +: 4]);
                if (rate_cmd_last) begin
                    s_nxt.st    = ST_IDLE;
                    s_nxt.vld_n = 1'b1;
                    s_nxt.oe_n  = 1'b1;
                    s_nxt.rdy   = bus.bus_takeover_req_n;
                end else if (s_nxt.gap != 3'h0) begin
                    s_nxt.st    = ST_WGAP;
                    s_nxt.vld_n = 1'b1;
                    s_nxt.wcnt  = s_r.wcnt + 4'h1;
                end else begin
                    s_nxt.wcnt  = s_r.wcnt + 4'h1;
                    s_nxt.ad    = req_wdata;
                    s_nxt.take  = 1'b1;
                    s_nxt.cmd[sysbus_pkg::CMD_LAST_BIT] =
                        (s_r.wcnt == 4'(sysbus_pkg::BLK_WORDS - 2));
                end
            end
            ST_WGAP: begin
                s_nxt.gap = s_r.gap - 3'h1;
                if (s_r.gap == 3'h1) begin
                    s_nxt.st    = ST_WDATA;
                    s_nxt.vld_n = 1'b0;
                    s_nxt.ad    = req_wdata;
                    s_nxt.take  = 1'b1;
                    s_nxt.cmd[sysbus_pkg::CMD_LAST_BIT] =
                        (s_r.wcnt == 4'(sysbus_pkg::BLK_WORDS - 1));
                end
            end
            ST_RWAIT, ST_SLAVE: begin
                // agent paces the read data entirely
                if (!bus.agent_drive_valid_n) begin
                    if (cmd_is_data) begin
                        s_nxt.rv = 1'b1;
                        s_nxt.rd = bus.sys_addr_data_bus;
                        s_nxt.rl = bus.sys_command_bus[
                            sysbus_pkg::CMD_LAST_BIT];
                        s_nxt.rp = (sysbus_pkg::lane_par(
                            bus.sys_addr_data_bus)
                            != bus.addr_data_check_bits)
                            || (^bus.sys_command_bus != bus.cmd_par);
                    end
                end
                // read done on last word; takeover ends on request drop
                if ((s_r.st == ST_RWAIT && !bus.agent_drive_valid_n
                     && cmd_is_data
                     && bus.sys_command_bus[sysbus_pkg::CMD_LAST_BIT])
                    || (s_r.st == ST_SLAVE && bus.bus_takeover_req_n)) begin
                    s_nxt.st    = ST_IDLE;
                    s_nxt.rel_n = 1'b1;
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase
    end

    // all state in one register
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s_r       <= '0;
            s_r.st    <= ST_IDLE;
            s_r.oe_n  <= 1'b1;
            s_r.vld_n <= 1'b1;
            s_r.rel_n <= 1'b1;
            s_r.mult  <= 4'(sysbus_pkg::MULT_MIN);
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus.ad_cpu_out        = s_r.ad;
    assign bus.chk_cpu_out       = sysbus_pkg::lane_par(s_r.ad);
    assign bus.cmd_cpu_out       = s_r.cmd;
    assign bus.cmd_par_cpu       = ^s_r.cmd;
    assign bus.ad_cpu_oe_n       = s_r.oe_n;
    assign bus.cpu_drive_valid_n = s_r.vld_n;
    assign bus.release_n         = s_r.rel_n;
    assign bus.mode_clk          = s_r.sclk;
    assign req_ready   = s_r.rdy;
    assign wdata_take  = s_r.take;
    assign rdata_valid = s_r.rv;
    assign rdata       = s_r.rd;
    assign rdata_last  = s_r.rl;
    assign rdata_perr  = s_r.rp;
    assign mode_done   = s_r.done;
    assign mode_word   = s_r.mode;
    assign pll_mult    = s_r.mult;
endmodule : sysbus_cpu_end
`default_nettype wire

// *** verilog/sysbus_agent_end.sv ***
`timescale 1ns/10ps
`default_nettype none
module sysbus_agent_end (
    input  wire logic         ref_clk,    // bus reference clock
    input  wire logic         resetn,     // synchronous reset
    sysbus_if.agent           bus,        // system interface
    input  wire logic         rd_ok,      // can accept a read
    input  wire logic         wr_ok,      // can accept a write
    input  wire logic         take_req,   // ask for the bus
    input  wire logic [255:0] boot_bits,  // mode stream image
    input  wire logic         rsp_valid,  // read response word ready
    input  wire logic [31:0]  rsp_data,   // read response word
    output logic              rsp_take,   // response word consumed
    output logic              cmd_valid,  // cpu request seen
    output logic              cmd_write,  // request is a write
    output logic [31:0]       cmd_addr,   // request address
    output logic [8:0]        cmd_code,   // request command
    output logic              wd_valid,   // write word strobe
    output logic [31:0]       wd_data,    // write word
    output logic              wd_last     // last write word
);
    typedef struct packed {
        logic         rrdy_n;
        logic         wrdy_n;
        logic         ext_n;
        logic         oe_n;
        logic         vld_n;
        logic [31:0]  ad;
        logic [8:0]   cmd;
        logic         rblk;
        logic [3:0]   rcnt;
        logic         rpend;
        logic         take;
        logic         cv;
        logic         cw;
        logic [31:0]  ca;
        logic [8:0]   cc;
        logic         wv;
        logic [31:0]  wd;
        logic         wl;
        logic         sclk_d;
        logic [8:0]   bit_idx;
        logic         din;
    } st_s;

    st_s  s_r;
    st_s  s_nxt;
    logic cpu_word;

    assign cpu_word = !bus.cpu_drive_valid_n && !bus.ad_cpu_oe_n;

    always_comb begin
        s_nxt        = s_r;
        s_nxt.take   = 1'b0;
        s_nxt.cv     = 1'b0;
        s_nxt.wv     = 1'b0;
        s_nxt.vld_n  = 1'b1;
        s_nxt.rrdy_n = !rd_ok;
        s_nxt.wrdy_n = !wr_ok;
        s_nxt.ext_n  = !(take_req && !s_r.rpend);
        s_nxt.sclk_d = bus.mode_clk;
        // one bit per serial period, new bit on the falling edge
        if (!bus.power_good) begin
            s_nxt.bit_idx = '0;
            s_nxt.din     = boot_bits[0];
        end else if (s_r.sclk_d && !bus.mode_clk
                     && s_r.bit_idx != 9'(sysbus_pkg::MODE_BITS - 1)) begin
            s_nxt.bit_idx = s_r.bit_idx + 9'h001;
            s_nxt.din     = boot_bits[s_nxt.bit_idx[7:0]];
        end
        // decode cpu words
        if (cpu_word) begin
            if (!bus.sys_command_bus[sysbus_pkg::CMD_DATA_BIT]) begin
                s_nxt.cv = 1'b1;
                s_nxt.cw = bus.sys_command_bus[
                    sysbus_pkg::CMD_TYPE_LSB +: 3] == sysbus_pkg::TYPE_WRITE;
                s_nxt.ca = bus.sys_addr_data_bus;
                s_nxt.cc = bus.sys_command_bus;
                if (!s_nxt.cw) begin
                    s_nxt.rpend = 1'b1;
                    s_nxt.rblk  = bus.sys_command_bus[
                        sysbus_pkg::CMD_BLK_BIT];
                    s_nxt.rcnt  = 4'h0;
                end
            end else begin
                s_nxt.wv = 1'b1;
                s_nxt.wd = bus.sys_addr_data_bus;
                s_nxt.wl = bus.sys_command_bus[sysbus_pkg::CMD_LAST_BIT];
            end
        end
        // drive read response once the cpu has released
        s_nxt.oe_n = bus.release_n;
        if (!bus.release_n && s_r.rpend && rsp_valid && !s_r.take) begin
            s_nxt.take  = 1'b1;
            s_nxt.vld_n = 1'b0;
            s_nxt.ad    = rsp_data;
            s_nxt.cmd   = '0;
            s_nxt.cmd[sysbus_pkg::CMD_DATA_BIT] = 1'b1;
            s_nxt.rcnt  = s_r.rcnt + 4'h1;
            if (!s_r.rblk
                || s_r.rcnt == 4'(sysbus_pkg::BLK_WORDS - 1)) begin
                s_nxt.cmd[sysbus_pkg::CMD_LAST_BIT] = 1'b1;
                s_nxt.rpend = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s_r        <= '0;
            s_r.rrdy_n <= 1'b1;
            s_r.wrdy_n <= 1'b1;
            s_r.ext_n  <= 1'b1;
            s_r.oe_n   <= 1'b1;
            s_r.vld_n  <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus.ad_agt_out          = s_r.ad;
    assign bus.chk_agt_out         = sysbus_pkg::lane_par(s_r.ad);
    assign bus.cmd_agt_out         = s_r.cmd;
    assign bus.cmd_par_agt         = ^s_r.cmd;
    assign bus.ad_agt_oe_n         = s_r.oe_n;
    assign bus.agent_drive_valid_n = s_r.vld_n;
    assign bus.read_accept_n       = s_r.rrdy_n;
    assign bus.write_accept_n      = s_r.wrdy_n;
    assign bus.bus_takeover_req_n  = s_r.ext_n;
    assign bus.mode_din            = s_r.din;
    assign rsp_take  = s_r.take;
    assign cmd_valid = s_r.cv;
    assign cmd_write = s_r.cw;
    assign cmd_addr  = s_r.ca;
    assign cmd_code  = s_r.cc;
    assign wd_valid  = s_r.wv;
    assign wd_data   = s_r.wd;
    assign wd_last   = s_r.wl;
endmodule : sysbus_agent_end
`default_nettype wire

// *** dv/sysbus_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module sysbus_chk (
    input wire logic        ref_clk,              // clock
    input wire logic        resetn,               // reset
    input wire logic [31:0] sys_addr_data_bus,    // ad
    input wire logic [3:0]  addr_data_check_bits, // check
    input wire logic [8:0]  sys_command_bus,      // cmd
    input wire logic        cmd_par,              // cmd par
    input wire logic        read_accept_n,        // rd ok
    input wire logic        write_accept_n,       // wr ok
    input wire logic        bus_takeover_req_n,   // takeover
    input wire logic        release_n,            // released
    input wire logic        cpu_drive_valid_n,    // cpu valid
    input wire logic        ad_cpu_oe_n,          // cpu drives
    input wire logic        mode_clk              // serial clk
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic [7:0] gap_r;
    logic       clk_q_r;
    logic       seen_r;
    // a slipped serial edge would shift every boot bit
    always_ff @(posedge ref_clk) begin
        clk_q_r <= mode_clk;
        gap_r   <= (!resetn || mode_clk != clk_q_r) ? 8'h00 : gap_r + 8'h01;
        seen_r  <= resetn && (seen_r || mode_clk != clk_q_r);
    end
    a_cmd_parity:
    assert property (!cpu_drive_valid_n |-> cmd_par == ^sys_command_bus)
        else $error("command parity wrong");
    a_check_bits:
    assert property (!cpu_drive_valid_n |-> addr_data_check_bits ==
        {^sys_addr_data_bus[31:24], ^sys_addr_data_bus[23:16],
         ^sys_addr_data_bus[15:8], ^sys_addr_data_bus[7:0]})
        else $error("check bits wrong");
    a_valid_drives:
    assert property (!cpu_drive_valid_n |-> !ad_cpu_oe_n)
        else $error("valid without drive");
    a_release_off:
    assert property (!release_n |-> ad_cpu_oe_n && cpu_drive_valid_n)
        else $error("driving while released");
    a_addr_first:
    assert property ($fell(cpu_drive_valid_n) && $fell(ad_cpu_oe_n)
        |-> !sys_command_bus[8])
        else $error("request without address cycle");
    a_addr_hold:
    assert property (!cpu_drive_valid_n && !sys_command_bus[8] &&
        read_accept_n && write_accept_n
        |=> !cpu_drive_valid_n && $stable(sys_addr_data_bus))
        else $error("address dropped early");
    a_read_release:
    assert property (!cpu_drive_valid_n && !read_accept_n &&
        sys_command_bus[8:5] == {1'b0, sysbus_pkg::TYPE_READ} |=> !release_n)
        else $error("no release after read accept");
    a_takeover_grant:
    assert property (!bus_takeover_req_n && release_n && ad_cpu_oe_n
        |-> ##[1:2] !release_n)
        else $error("takeover not granted");
    a_serial_rate:
    assert property (seen_r && mode_clk != clk_q_r |-> gap_r == 8'h7F)
        else $error("serial clock rate wrong");
    c_release: cover property (!release_n && !bus_takeover_req_n);
    c_data_out: cover property (!cpu_drive_valid_n && sys_command_bus[8]);
    c_rd_accept: cover property ($fell(read_accept_n));
endmodule : sysbus_chk
`default_nettype wire

// *** dv/test_cpu_system_bus_interface.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_cpu_system_bus_interface;
    logic ref_clk, resetn, req_valid, req_write, req_block, rd_ok, wr_ok;
    logic take_req, rsp_valid, req_ready, wdata_take, rdata_valid, rsp_take;
    logic rdata_last, rdata_perr, mode_done, cmd_valid, cmd_write, wd_valid;
    logic wd_last;
    logic [31:0]  req_addr, req_wdata, rsp_data, rdata, cmd_addr, wd_data;
    logic [2:0]   req_size, esz;
    logic [3:0]   pll_mult;
    logic [8:0]   cmd_code;
    logic [36:0]  ecmd;
    logic [255:0] mode_word, boot_bits;
    logic [31:0]  rq[$], eq[$], sq[$], wq[$];
    int           bad_count, tests_run, n, k;
    sysbus_if bus();
    sysbus_cpu_end u_sysbus_cpu_end (.*);
    sysbus_agent_end u_sysbus_agent_end (.*);
    sysbus_chk u_sysbus_chk (.ref_clk(ref_clk), .resetn(resetn),
        .sys_addr_data_bus(bus.sys_addr_data_bus),
        .addr_data_check_bits(bus.addr_data_check_bits),
        .sys_command_bus(bus.sys_command_bus), .cmd_par(bus.cmd_par),
        .read_accept_n(bus.read_accept_n),
        .write_accept_n(bus.write_accept_n),
        .bus_takeover_req_n(bus.bus_takeover_req_n),
        .release_n(bus.release_n), .cpu_drive_valid_n(bus.cpu_drive_valid_n),
        .ad_cpu_oe_n(bus.ad_cpu_oe_n), .mode_clk(bus.mode_clk));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [255:0] s, input logic [255:0] e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %0t seen %h exp %h", $time, s, e);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d bad %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict
    task automatic limit(input int lim);
        if (n >= lim) begin
            bad_count++;
            print_verdict();
        end
    endtask : limit
    // bench model: queues hold the words each side should see
    always @(posedge ref_clk) begin
        if (rdata_valid) begin
            check(rdata, eq.pop_front());
            check(rdata_last, eq.size() == 0);
            check(rdata_perr, 1'b0);
        end
        if (wd_valid) begin
            check(wd_data, wq.pop_front());
            check(wd_last, wq.size() == 0);
        end
        if (cmd_valid) begin
            check({cmd_write, cmd_code[7:5], cmd_code[3], cmd_addr}, ecmd);
            if (!cmd_code[3]) check(cmd_code[2:0], esz);
        end
        if (wdata_take && sq.size() != 0) void'(sq.pop_front());
        if (wdata_take) req_wdata <= sq.size() != 0 ? sq[0] : ~req_wdata;
        if (rsp_take && rq.size() != 0) void'(rq.pop_front());
        if (rsp_take) rsp_data <= rq.size() != 0 ? rq[0] : ~rsp_data;
        if (rsp_take) rsp_valid <= rq.size() != 0;
    end
    // one request at a time; waits for the reply before returning
    task automatic issue(input logic w, input logic b, input logic [2:0] s);
        logic [31:0] a;
        a = $urandom;
        if (b || s != 3'h0) a[4:0] = 5'h00;
        for (int i = 0; i <= (b ? 7 : 0); i++) begin
            if (w) sq.push_back($urandom);
            if (w) wq.push_back(sq[$]);
            else rq.push_back($urandom);
            if (!w) eq.push_back(rq[$]);
        end
        ecmd = {w, w ? sysbus_pkg::TYPE_WRITE : sysbus_pkg::TYPE_READ, b, a};
        esz = s;
        for (n = 0; n < 500 && req_ready !== 1'b1; n++) @(posedge ref_clk);
        limit(500);
        {req_valid, req_write, req_block, req_addr, req_size} <= {1'b1, w, b, a, s};
        if (w) req_wdata <= sq[0];
        else {rsp_valid, rsp_data} <= {1'b1, rq[0]};
        @(posedge ref_clk);
        req_valid <= 1'b0;
        for (n = 0; n < 3000 && (eq.size() || wq.size() || req_ready !== 1'b1);
             n++) @(posedge ref_clk);
        limit(3000);
    endtask : issue
    initial begin
        {req_valid, req_write, req_block, req_addr, req_size} = '0;
        {req_wdata, rsp_valid, rsp_data, take_req, rd_ok, wr_ok} = {66'h0, 2'h3};
        {bad_count, tests_run, resetn, bus.power_good} = '0;
        void'($urandom(90));
        for (k = 0; k < 8; k++) boot_bits[k*32 +: 32] = $urandom;
        boot_bits[255:12] = 244'h1;
        boot_bits[7:0] = {3'($urandom_range(6, 0)), 4'($urandom_range(8, 1)), 1'b0};
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        // agent loads bit 0 only while power good is still low
        repeat (2) @(posedge ref_clk);
        bus.power_good <= 1'b1;
        for (n = 0; n < 70000 && mode_done !== 1'b1; n++) @(posedge ref_clk);
        limit(70000);
        check(mode_word, boot_bits);
        check(pll_mult, boot_bits[7:5] + 4'h2);
        // every kind and byte count, some with the agent stalling
        for (k = 0; k < 12; k++) begin
            {rd_ok, wr_ok} <= (k > 7) ? 2'h0 : 2'h3;
            fork
                issue(k[0], k > 7 ? k[1] : 1'b0, 3'(k));
                begin
                    repeat (20) @(posedge ref_clk);
                    {rd_ok, wr_ok} <= 2'h3;
                end
            join
        end
        // the agent takes the bus while idle, then gives it back
        take_req <= 1'b1;
        for (n = 0; n < 50 && bus.release_n !== 1'b0; n++) @(posedge ref_clk);
        check(bus.release_n, 1'b0);
        take_req <= 1'b0;
        repeat (10) @(posedge ref_clk);
        check(bus.release_n, 1'b1);
        print_verdict();
    end
endmodule : test_cpu_system_bus_interface
`default_nettype wire
